/* hdl/sgl_pkg.sv */
package sgl_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned REG_SETTLE_NS = 1000; // regulator settling, least
  localparam int unsigned SETTLE_CYC = (REG_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LOCK_REF_CYC = 200; // lock bound in reference cycles
  localparam int unsigned REF_HZ = 125_000_000;
  localparam int unsigned LOCK_CYC_RAW = (LOCK_REF_CYC * CLK_MHZ) / (REF_HZ / 1_000_000);
  localparam int unsigned LOCK_CYC = (LOCK_CYC_RAW < 1) ? 1 : LOCK_CYC_RAW;
  localparam int unsigned LINE_RATE_KBPS = 1_250_000; // only line rate
  localparam logic [3:0] MPY_STD = 4'h5; // multiplier giving the line rate
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_ADV = 8'h08;
  localparam logic [7:0] A_AUX = 8'h0c;
  localparam logic [7:0] A_TXC = 8'h10;
  localparam logic [7:0] A_RXC = 8'h14;
  localparam logic [7:0] A_CDR = 8'h18;
  // ==========================================================
  // field positions
  localparam int unsigned F_EN = 0; // enable bit in ctrl, aux, tx and rx cfg
  localparam int unsigned F_RATE = 1; // rate field, two bits
  localparam int unsigned F_MPY = 1; // multiply factor, four bits
  localparam int unsigned F_LOSEN = 3;
  localparam int unsigned F_CDR = 4; // 0 first order, 1 second order enabled
  localparam int unsigned F_ALIGN = 6; // two bits
  localparam int unsigned S_LINK = 0;
  localparam int unsigned S_DONE = 1;
  localparam int unsigned S_ERR = 2;
  localparam int unsigned S_LOCK = 3;
  localparam int unsigned P_LINK = 15; // partner word fields
  localparam int unsigned P_FDX = 12;
  localparam int unsigned P_SPD = 10;
  localparam logic [1:0] SPD_GIG = 2'h2;
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QTR = 2'h2;
  localparam logic [1:0] ALIGN_COMMA = 2'h1;
  localparam logic [6:0] COMMA_P = 7'h7c; // comma seven bits, both polarities
  localparam logic [6:0] COMMA_N = 7'h03;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  typedef enum {AN_IDLE, AN_WAIT, AN_DONE} sgl_an_t;
endpackage

/* hdl/sgl_cdr.sv */
`timescale 1ns/1ps
module sgl_cdr
  import sgl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_run,
  input wire logic i_win_valid,
  input wire logic [7:0] i_data,
  input wire logic [8:0] i_phase,
  input wire logic i_second_order,
  output logic [7:0] o_phase_q,
  output logic signed [5:0] o_freq_q
);
  // ==========================================================
  // vote per adjacent data pair; data[7] is seen again as next dext[0]
  logic last_q;
  logic [7:0] early;
  logic [7:0] late;
  logic [8:0] dext;
  assign dext = {i_data, last_q};
  for (genvar i = 0; i < 8; i++) begin : g_vote
    assign late[i] = (dext[i] != dext[i + 1]) && (i_phase[i] == dext[i]); // RULE14
    assign early[i] = (dext[i] != dext[i + 1]) && (i_phase[i] != dext[i]); // RULE14
  end
  logic [3:0] n_early;
  logic [3:0] n_late;
  always_comb begin
    n_early = 4'h0;
    n_late = 4'h0;
    for (int k = 0; k < 8; k++) begin
      n_early = n_early + {3'h0, early[k]};
      n_late = n_late + {3'h0, late[k]};
    end
  end
  logic mv_late;
  logic mv_early;
  assign mv_late = n_late > n_early; // RULE15
  assign mv_early = n_early > n_late; // RULE15
  // ==========================================================
  // phase and drift integrators, frozen while not running
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_q <= 1'b0;
      o_phase_q <= 8'h00;
      o_freq_q <= 6'sh00;
    end else if (i_run && i_win_valid) begin // RULE13
      last_q <= i_data[7];
      if (i_second_order) begin
        o_freq_q <= o_freq_q + (mv_late ? 6'sh01 : 6'sh00) - (mv_early ? 6'sh01 : 6'sh00); // RULE17
        o_phase_q <= o_phase_q + 8'(o_freq_q) + (mv_late ? 8'h01 : 8'h00)
                     - (mv_early ? 8'h01 : 8'h00); // RULE17
      end else begin
        o_phase_q <= o_phase_q + (mv_late ? 8'h01 : 8'h00) - (mv_early ? 8'h01 : 8'h00); // RULE16
      end
    end
  end

  chk_first_order_step: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // RULE16
    i_run && i_win_valid && !i_second_order && mv_late |=> o_phase_q == $past(o_phase_q) + 8'h01)
    else $error("first order late step wrong");
  chk_freeze_holds: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // RULE13
    !i_run |=> $stable(o_phase_q) && $stable(o_freq_q))
    else $error("recovery moved while frozen");
  chk_no_majority: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // RULE15
    i_run && i_win_valid && !i_second_order && n_early == n_late |=> $stable(o_phase_q))
    else $error("phase moved without majority");
endmodule // sgl_cdr

/* hdl/sgl_link_ctrl.sv */
`timescale 1ns/1ps
// Operation
// RULE1 - software writes one to advertised ability and control to start negotiation
// RULE2 - software polls status until negotiation done without error
// RULE3 - fault flag set when partner commands half duplex at gigabit
// RULE4 - software lets link adapter signals set mac speed and duplex
// RULE5 - software never selects the eight-bit pll mode
// RULE6 - software waits one microsecond after pll enable for the regulator
// RULE7 - pll locks within 200 reference cycles after settling
// RULE8 - link runs only at the standard 1.25 Gbps line rate
// RULE9 - rate field: 00 two samples, 01 one, 10 one per two cycles
// RULE10 - receiver and transmitter each hold their own rate field
// RULE11 - transmitter disabled gates its logic but byte clock keeps running
// RULE12 - receiver disabled gates off all receiver logic and clocks
// RULE13 - loss of signal with monitoring enabled freezes clock recovery
// RULE14 - differing adjacent samples make the middle phase sample one vote
// RULE15 - votes gathered over eight data samples; adjust only on majority
// RULE16 - first order recovery takes one step per majority
// RULE17 - second order recovery steps by net drift, can be disabled
// RULE18 - align field 01 aligns symbols to comma symbols
// RULE19 - single-bit jog input lets core logic shift alignment
// RULE20 - loopback change: clear negotiation, soft reset, set loopback, release
// RULE21 - software waits for pll settle and lock before enabling anything
module sgl_link_ctrl
  import sgl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [15:0] i_partner_cfg,
  input wire logic i_partner_cfg_valid,
  input wire logic i_los,
  input wire logic [9:0] i_rx_word,
  input wire logic i_rx_word_valid,
  input wire logic i_align_jog,
  input wire logic i_cdr_win_valid,
  input wire logic [7:0] i_cdr_data,
  input wire logic [8:0] i_cdr_phase,
  output logic o_pll_en,
  output logic o_tx_byte_clk,
  output logic o_tx_clk_en,
  output logic o_rx_clk_en,
  output logic [1:0] o_tx_smp_cnt,
  output logic [1:0] o_rx_smp_cnt,
  output logic [9:0] o_rx_sym,
  output logic o_rx_sym_valid,
  output logic o_link_up,
  output logic o_gig_full_duplex
);
  // ==========================================================
  // registers
  logic [31:0] ctrl_q, adv_q, aux_q, txc_q, rxc_q;
  logic an_done_q, an_err_q, pll_lock_q;
  logic [7:0] cdr_phase;
  logic signed [5:0] cdr_freq;
  logic wr_go, rd_go;
  logic [31:0] wmask;
  assign wmask = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}}, {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
  assign wr_go = i_awvalid && i_wvalid && !o_bvalid;
  assign rd_go = i_arvalid && !o_rvalid;

  // ==========================================================
  // write channel: address and data taken together, response next cycle
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OK;
    end else begin
      o_awready <= wr_go && !o_awready;
      o_wready <= wr_go && !o_wready;
      if (wr_go && !o_awready) begin
        o_bvalid <= 1'b1;
        o_bresp <= (i_awaddr inside {A_CTRL, A_ADV, A_AUX, A_TXC, A_RXC})
                   ? RESP_OK : RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // config register storage with byte strobes
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= RST_ZERO;
      adv_q <= RST_ZERO;
      aux_q <= RST_ZERO;
      txc_q <= RST_ZERO;
      rxc_q <= RST_ZERO;
    end else if (wr_go && !o_awready) begin
      case (i_awaddr)
        A_CTRL: ctrl_q <= (ctrl_q & ~wmask) | (i_wdata & wmask);
        A_ADV: adv_q <= (adv_q & ~wmask) | (i_wdata & wmask);
        A_AUX: aux_q <= (aux_q & ~wmask) | (i_wdata & wmask);
        A_TXC: txc_q <= (txc_q & ~wmask) | (i_wdata & wmask); // RULE10
        A_RXC: rxc_q <= (rxc_q & ~wmask) | (i_wdata & wmask); // RULE10
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read channel: data one cycle after address taken
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= RST_ZERO;
      o_rresp <= RESP_OK;
    end else begin
      o_arready <= rd_go && !o_arready;
      if (rd_go && !o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp <= RESP_OK;
        case (i_araddr)
          A_CTRL: o_rdata <= ctrl_q;
          A_ADV: o_rdata <= adv_q;
          A_AUX: o_rdata <= aux_q;
          A_TXC: o_rdata <= txc_q;
          A_RXC: o_rdata <= rxc_q;
          A_STAT: o_rdata <= {28'h0, pll_lock_q, an_err_q, an_done_q, o_link_up};
          A_CDR: o_rdata <= {18'h0, cdr_freq, cdr_phase};
          default: begin
            o_rdata <= RST_ZERO;
            o_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pll settle then lock timing
  logic [8:0] pll_cnt_q;
  logic mpy_ok;
  assign mpy_ok = aux_q[F_MPY +: 4] == MPY_STD; // RULE8
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pll_cnt_q <= 9'h000;
      pll_lock_q <= 1'b0;
      o_pll_en <= 1'b0;
    end else begin
      o_pll_en <= aux_q[F_EN];
      if (!aux_q[F_EN] || !mpy_ok) begin
        pll_cnt_q <= 9'h000;
        pll_lock_q <= 1'b0;
      end else if (pll_cnt_q == 9'(SETTLE_CYC + LOCK_CYC - 1)) begin
        pll_lock_q <= 1'b1; // RULE7
      end else begin
        pll_cnt_q <= pll_cnt_q + 9'h001;
      end
    end
  end

  // ==========================================================
  // loss of signal pin synchroniser
  logic los_s1_q, los_s2_q;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      los_s1_q <= 1'b0;
      los_s2_q <= 1'b0;
    end else begin
      los_s1_q <= i_los;
      los_s2_q <= los_s1_q;
    end
  end

  // ==========================================================
  // auto-negotiation: wait for partner word, then report outcome
  sgl_an_t an_q;
  logic hdx_gig;
  assign hdx_gig = (i_partner_cfg[P_SPD +: 2] == SPD_GIG) && !i_partner_cfg[P_FDX];
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      an_q <= AN_IDLE;
      an_done_q <= 1'b0;
      an_err_q <= 1'b0;
      o_link_up <= 1'b0;
      o_gig_full_duplex <= 1'b0;
    end else begin
      case (an_q)
        AN_IDLE: begin
          if (ctrl_q[F_EN] && pll_lock_q) begin
            an_q <= AN_WAIT;
          end
          an_done_q <= 1'b0;
          an_err_q <= 1'b0;
          o_link_up <= 1'b0;
        end
        AN_WAIT: begin
          if (!ctrl_q[F_EN]) begin
            an_q <= AN_IDLE;
          end else if (i_partner_cfg_valid) begin
            an_q <= AN_DONE;
            an_done_q <= 1'b1;
            an_err_q <= hdx_gig; // RULE3
            o_link_up <= i_partner_cfg[P_LINK] && !hdx_gig;
            o_gig_full_duplex <= !hdx_gig && (i_partner_cfg[P_SPD +: 2] == SPD_GIG);
          end
        end
        AN_DONE: begin
          if (i_partner_cfg_valid && hdx_gig) begin
            an_err_q <= 1'b1; // RULE3
          end
          if (!ctrl_q[F_EN] || !pll_lock_q) begin
            an_q <= AN_IDLE;
          end
        end
        default: an_q <= AN_IDLE;
      endcase
    end
  end

  // ==========================================================
  // byte clock runs free; enables gate direction logic
  logic [1:0] phase_cnt_q;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx_byte_clk <= 1'b0;
      o_tx_clk_en <= 1'b0;
      o_rx_clk_en <= 1'b0;
      phase_cnt_q <= 2'h0;
    end else begin
      o_tx_byte_clk <= !o_tx_byte_clk; // RULE11
      o_tx_clk_en <= txc_q[F_EN]; // RULE11
      o_rx_clk_en <= rxc_q[F_EN]; // RULE12
      phase_cnt_q <= phase_cnt_q + 2'h1;
    end
  end

  // per-direction sample count per pll cycle
  logic [1:0] rate_sel [2];
  logic dir_en [2];
  logic [1:0] smp_q [2];
  assign rate_sel[0] = txc_q[F_RATE +: 2];
  assign rate_sel[1] = rxc_q[F_RATE +: 2];
  assign dir_en[0] = txc_q[F_EN];
  assign dir_en[1] = rxc_q[F_EN];
  for (genvar d = 0; d < 2; d++) begin : g_rate
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        smp_q[d] <= 2'h0;
      end else if (!dir_en[d]) begin
        smp_q[d] <= 2'h0;
      end else begin
        case (rate_sel[d]) // RULE9
          RATE_FULL: smp_q[d] <= 2'h2;
          RATE_HALF: smp_q[d] <= 2'h1;
          RATE_QTR: smp_q[d] <= {1'b0, phase_cnt_q[0]};
          default: smp_q[d] <= 2'h0;
        endcase
      end
    end
  end
  assign o_tx_smp_cnt = smp_q[0];
  assign o_rx_smp_cnt = smp_q[1];

  // ==========================================================
  // symbol alignment: comma search or core jog
  logic [9:0] prev_q;
  logic [3:0] off_q;
  logic [19:0] cat;
  logic [9:0] hit;
  assign cat = {i_rx_word, prev_q};
  for (genvar b = 0; b < 10; b++) begin : g_comma
    assign hit[b] = (cat[b +: 7] == COMMA_P) || (cat[b +: 7] == COMMA_N);
  end
  logic [3:0] hit_off;
  always_comb begin
    hit_off = off_q;
    for (int k = 9; k >= 0; k--) begin
      if (hit[k]) begin
        hit_off = 4'(k);
      end
    end
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_q <= 10'h000;
      off_q <= 4'h0;
      o_rx_sym <= 10'h000;
      o_rx_sym_valid <= 1'b0;
    end else if (!rxc_q[F_EN]) begin // RULE12
      o_rx_sym_valid <= 1'b0;
    end else begin
      o_rx_sym_valid <= i_rx_word_valid;
      if (i_rx_word_valid) begin
        prev_q <= i_rx_word;
        o_rx_sym <= cat[off_q +: 10];
        if (i_align_jog) begin
          off_q <= (off_q == 4'h9) ? 4'h0 : off_q + 4'h1; // RULE19
        end else if (rxc_q[F_ALIGN +: 2] == ALIGN_COMMA && |hit) begin
          off_q <= hit_off; // RULE18
        end
      end
    end
  end

  // ==========================================================
  // clock recovery, frozen on loss of signal with monitoring enabled, or receiver off
  logic cdr_run;
  assign cdr_run = rxc_q[F_EN] && !(rxc_q[F_LOSEN] && los_s2_q); // RULE13
  sgl_cdr u_cdr (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_run(cdr_run),
    .i_win_valid(i_cdr_win_valid),
    .i_data(i_cdr_data),
    .i_phase(i_cdr_phase),
    .i_second_order(rxc_q[F_CDR]),
    .o_phase_q(cdr_phase),
    .o_freq_q(cdr_freq)
  );

  // edges from the enable being seen to the last edge without lock
  localparam int LOCK_DLY = SETTLE_CYC + LOCK_CYC - 1;
  chk_hdx_gig_fault: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // RULE3
    an_q == AN_WAIT && ctrl_q[F_EN] && i_partner_cfg_valid && hdx_gig |=> an_err_q && an_done_q)
    else $error("half duplex gigabit not flagged");
  chk_pll_lock_time: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // RULE7
    $rose(aux_q[F_EN]) && mpy_ok |-> ##LOCK_DLY !pll_lock_q ##1 pll_lock_q)
    else $error("pll lock timing wrong");
  chk_byte_clk_runs: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // RULE11
    i_arst_n && !txc_q[F_EN] |=> o_tx_byte_clk != $past(o_tx_byte_clk))
    else $error("byte clock stopped");
  chk_rx_off_gates: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // RULE12
    !rxc_q[F_EN] |=> !o_rx_sym_valid && !o_rx_clk_en && o_rx_smp_cnt == 2'h0)
    else $error("receiver active while off");
  chk_full_rate_cnt: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // RULE9
    txc_q[F_EN] && txc_q[F_RATE +: 2] == RATE_FULL |=> o_tx_smp_cnt == 2'h2)
    else $error("full rate sample count wrong");
  chk_jog_shift: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // RULE19
    rxc_q[F_EN] && i_rx_word_valid && i_align_jog && off_q < 4'h9 |=> off_q == $past(off_q) + 4'h1)
    else $error("jog did not shift alignment");
endmodule // sgl_link_ctrl

/* verification/sgl_phy_model.sv */
`timescale 1ns/1ps
// ==========================================================
// far-side phy and line sampler stimulus
module sgl_phy_model
  import sgl_pkg::*;
(
  input wire logic i_mclk,
  output logic [15:0] o_cfg,
  output logic o_cfg_valid,
  output logic o_los,
  output logic [9:0] o_word,
  output logic o_word_valid,
  output logic o_jog,
  output logic o_win_valid,
  output logic [7:0] o_data,
  output logic [8:0] o_phase
);
  // quiet line at time zero
  initial begin
    o_cfg = 16'h0;
    o_cfg_valid = 1'h0;
    o_los = 1'h0;
    o_word = 10'h0;
    o_word_valid = 1'h0;
    o_jog = 1'h0;
    o_win_valid = 1'h0;
    o_data = 8'h0;
    o_phase = 9'h0;
  end
  // negotiation word, one pulse, then inverted
  task automatic send_cfg(input logic [15:0] w);
    o_cfg <= w;
    o_cfg_valid <= 1'h1;
    @(posedge i_mclk);
    o_cfg <= ~w;
    o_cfg_valid <= 1'h0;
  endtask
  // raw word with optional jog request
  task automatic send_word(input logic [9:0] w, input logic j);
    o_word <= w;
    o_word_valid <= 1'h1;
    o_jog <= j;
    @(posedge i_mclk);
    o_word <= ~w;
    o_word_valid <= 1'h0;
    o_jog <= 1'h0;
  endtask
  // one voting window of samples
  task automatic send_win(input logic [7:0] d, input logic [8:0] p);
    o_data <= d;
    o_phase <= p;
    o_win_valid <= 1'h1;
    @(posedge i_mclk);
    o_data <= ~d;
    o_phase <= ~p;
    o_win_valid <= 1'h0;
  endtask
  // signal amplitude lost or back
  task automatic set_los(input logic v);
    o_los <= v;
  endtask
endmodule // sgl_phy_model

/* verification/sgl_link_ctrl_tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// bench top
module sgl_link_ctrl_tb_top
  import sgl_pkg::*;
();
  logic mclk = 1'h0;
  logic arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, pll_en, tbclk, b0;
  logic txen, rxen, symv, link_up, gfd, seen, pcfg_v, los, wv, jog, winv;
  logic [1:0] bresp, rresp, txs, rxs, r;
  logic [9:0] sym, s, word;
  logic [15:0] pcfg;
  logic [7:0] cdat;
  logic [8:0] cph;
  logic [19:0] pr;
  logic [3:0] wstrb;
  int errors = 0;
  int comparisons = 0;
  always #25 mclk = ~mclk;
  sgl_link_ctrl uut (.i_mclk(mclk), .i_arst_n(arst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_partner_cfg(pcfg), .i_partner_cfg_valid(pcfg_v), .i_los(los), .i_rx_word(word),
    .i_rx_word_valid(wv), .i_align_jog(jog), .i_cdr_win_valid(winv), .i_cdr_data(cdat),
    .i_cdr_phase(cph), .o_pll_en(pll_en), .o_tx_byte_clk(tbclk), .o_tx_clk_en(txen),
    .o_rx_clk_en(rxen), .o_tx_smp_cnt(txs), .o_rx_smp_cnt(rxs), .o_rx_sym(sym),
    .o_rx_sym_valid(symv), .o_link_up(link_up), .o_gig_full_duplex(gfd));
  sgl_phy_model phy (.i_mclk(mclk), .o_cfg(pcfg), .o_cfg_valid(pcfg_v), .o_los(los),
    .o_word(word), .o_word_valid(wv), .o_jog(jog), .o_win_valid(winv), .o_data(cdat),
    .o_phase(cph));
  // ==========================================================
  // compare and finish
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: response %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================================
  // axi4-lite master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rs = bresp;
    bready <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    axi_rd(a, v, rs);
    chk_resp(rs, RESP_OK);
    chk_val(v, e, "register read");
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // two settled samples of a sample counter
  task automatic chk_smp(input bit tx, input int k);
    logic [1:0] a, b;
    @(posedge mclk);
    #1 a = tx ? txs : rxs;
    @(posedge mclk);
    #1 b = tx ? txs : rxs;
    if (k == 2) chk_val(32'(a + b), 32'h1, "quarter rate");
    else chk_val(32'({a, b}), (k == 0) ? 32'ha : (k == 1) ? 32'h5 : 32'h0, "rate");
  endtask
  // wait a few cycles for an aligned symbol
  task automatic get_sym(output logic [9:0] v, output logic f);
    int n;
    n = 0;
    #1 f = (symv === 1'h1);
    while (!f && n < 4) begin
      @(posedge mclk);
      #1 f = (symv === 1'h1);
      n++;
    end
    v = sym;
  endtask
  // ==========================================================
  // watchdog, far above the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    stop_test;
  end
  // ==========================================================
  // main sequence
  initial begin
    arst_n = 1'h0;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (4) @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk);
    for (int i = 0; i < 7; i++) rd_chk(8'(i * 4), RST_ZERO);
    axi_rd(8'h1c, d, r);
    chk_resp(r, RESP_SLVERR);
    chk_val(d, RST_ZERO, "unmapped read");
    axi_wr(A_STAT, 32'hf, r);
    chk_resp(r, RESP_SLVERR);
    axi_wr(8'h20, 32'h1, r);
    chk_resp(r, RESP_SLVERR);
    // non-standard multiplier never locks
    axi_wr(A_AUX, 32'h9, r);
    wait_cyc(80);
    chk_val(32'(pll_en), 32'h1, "pll enable");
    rd_chk(A_STAT, 32'h0);
    axi_wr(A_AUX, 32'h0, r);
    axi_wr(A_AUX, 32'hb, r);
    wait_cyc(SETTLE_CYC + LOCK_CYC - 12);
    rd_chk(A_STAT, 32'h0);
    wait_cyc(12);
    rd_chk(A_STAT, 32'h8);
    // partner words ignored until enabled
    phy.send_cfg(16'h9800);
    wait_cyc(2);
    rd_chk(A_STAT, 32'h8);
    axi_wr(A_ADV, 32'h1, r);
    axi_wr(A_CTRL, 32'h1, r);
    rd_chk(A_ADV, 32'h1);
    // only the strobed byte lane is written
    wstrb <= 4'h2;
    axi_wr(A_ADV, 32'hffff_ffff, r);
    wstrb <= 4'hf;
    rd_chk(A_ADV, 32'h0000_ff01);
    phy.send_cfg(16'h9800);
    wait_cyc(2);
    chk_val(32'({link_up, gfd}), 32'h3, "gig full link");
    rd_chk(A_STAT, 32'hb);
    phy.send_cfg(16'h8800);
    wait_cyc(2);
    rd_chk(A_STAT, 32'hf);
    chk_val(32'(gfd), 32'h1, "duplex kept");
    axi_wr(A_CTRL, 32'h0, r);
    rd_chk(A_STAT, 32'h8);
    chk_val(32'(link_up), 32'h0, "link down");
    // half duplex gigabit as first word after restart
    axi_wr(A_CTRL, 32'h1, r);
    phy.send_cfg(16'h8800);
    wait_cyc(2);
    rd_chk(A_STAT, 32'he);
    chk_val(32'(link_up), 32'h0, "no link on fault");
    // every rate code, directions crossed
    for (int k = 0; k < 4; k++) begin
      axi_wr(A_TXC, 32'(k * 2 + 1), r);
      axi_wr(A_RXC, 32'((3 - k) * 2 + 1), r);
      chk_smp(1'b1, k);
      chk_smp(1'b0, 3 - k);
    end
    // transmitter off, byte clock still runs
    axi_wr(A_TXC, 32'h2, r);
    @(posedge mclk);
    #1 b0 = tbclk;
    @(posedge mclk);
    #1 chk_val(32'({txen, txs, tbclk ^ b0}), 32'h1, "tx off");
    // receiver off, no symbols
    axi_wr(A_RXC, 32'h2, r);
    phy.send_word(10'h155, 1'h0);
    get_sym(s, seen);
    chk_val(32'({rxen, rxs, seen}), 32'h0, "rx off");
    // jog moves alignment by one bit
    axi_wr(A_RXC, 32'h1, r);
    phy.send_word(10'h2b4, 1'h0);
    get_sym(s, seen);
    phy.send_word(10'h1c6, 1'h1);
    get_sym(s, seen);
    chk_val(32'(s), 32'h2b4, "before jog");
    phy.send_word(10'h0d9, 1'h0);
    get_sym(s, seen);
    pr = {10'h0d9, 10'h1c6};
    chk_val(32'(s), 32'(pr[10:1]), "after jog");
    // comma search realigns
    axi_wr(A_RXC, 32'h41, r);
    repeat (6) begin
      phy.send_word(10'h17c, 1'h0);
      get_sym(s, seen);
    end
    chk_val(32'(s[6:0] == COMMA_P || s[9:3] == COMMA_P), 32'h1, "comma");
    // clock recovery votes
    axi_wr(A_RXC, 32'h1, r);
    phy.send_win(8'h55, 9'h0aa);
    rd_chk(A_CDR, 32'h1);
    phy.send_win(8'h55, 9'h155);
    rd_chk(A_CDR, 32'h0);
    // one late and one early vote: a tie moves nothing
    phy.send_win(8'h0f, 9'h000);
    rd_chk(A_CDR, 32'h0);
    axi_wr(A_RXC, 32'h9, r);
    phy.set_los(1'h1);
    wait_cyc(4);
    phy.send_win(8'h55, 9'h0aa);
    rd_chk(A_CDR, 32'h0);
    phy.set_los(1'h0);
    axi_wr(A_RXC, 32'h11, r);
    wait_cyc(4);
    phy.send_win(8'h55, 9'h0aa);
    wait_cyc(1);
    phy.send_win(8'h55, 9'h0aa);
    axi_rd(A_CDR, d, r);
    chk_val(32'(d[13:8]), 32'h2, "drift rate");
    stop_test;
  end
endmodule // sgl_link_ctrl_tb_top
